// ==== hdl/bsci_top.sv ====
/*
  Boot serial command interpreter: bit-rate matching on the receive pin,
  frame parsing with checksum, inquiry and selection handling, erase
  hand-off and framed responses through a two-entry transmit buffer.
  Assumes a byte UART on the same clock delivers and sends bytes, and an
  erase engine answers o_erase_req with a one-cycle i_erase_done.
*/
`timescale 1ns/1ps
`include "bsci_params.svh"

module bsci_top (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_rxd,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  output logic [15:0]      o_bit_cycles,
  output logic             o_rate_locked,
  output logic             o_erase_req,
  input  wire logic        i_erase_done,
  output logic [7:0]       o_sel_mode,
  output logic [15:0]      o_new_rate,
  output logic             o_prog_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate matching on the raw receive pin
  logic                       rxd_meta_q;
  logic                       rxd_q;
  logic                       rxd_prev_q;
  logic [3:0]                 pre_q;
  logic [`BSCI_BIT_CNT_W-1:0] bit_cnt_q;
  bsci_pkg::bsci_phase_t      phase_q;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rxd_meta_q <= 1'b1;
      rxd_q      <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_meta_q <= i_rxd;
      rxd_q      <= rxd_meta_q;
      rxd_prev_q <= rxd_q;
    end
  end

  // Divide the low time by nine on the fly; no divider needed
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_q         <= 4'h0;
      bit_cnt_q     <= '0;
      o_bit_cycles  <= '0;
      o_rate_locked <= 1'b0;
    end else if (phase_q == bsci_pkg::BSCI_P_MATCH) begin
      if (rxd_prev_q && !rxd_q) begin
        pre_q     <= 4'h1;
        bit_cnt_q <= '0;
      end else if (!rxd_q) begin
        pre_q     <= (pre_q == `BSCI_LOW_BITS - 4'h1) ? 4'h0 : pre_q + 4'h1;
        bit_cnt_q <= (pre_q == `BSCI_LOW_BITS - 4'h1) ? bit_cnt_q + 1'b1 : bit_cnt_q;
      end else if (!rxd_prev_q && rxd_q && bit_cnt_q != '0) begin
        o_bit_cycles  <= bit_cnt_q;
        o_rate_locked <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame parser
  bsci_pkg::bsci_state_t state_q;
  logic [7:0]            cmd_q;
  logic [7:0]            size_q;
  logic [7:0]            left_q;
  logic [7:0]            sum_q;
  logic [31:0]           data_q;
  logic [7:0]            dev_sel_q;
  logic [7:0]            last_err_q;
  logic                  take;
  logic [7:0]            dec_cmd;
  logic [7:0]            dec_err;
  logic [8*`BSCI_RESP_BYTES-1:0] rvec;
  logic [3:0]            rlen;
  logic                  rframed;

  assign take = o_rx_ready && i_rx_valid;

  function automatic logic has_frame(input logic [7:0] c);
    has_frame = (c == `BSCI_CMD_SEL_DEV) || (c == `BSCI_CMD_SEL_MODE) ||
                (c == `BSCI_CMD_SEL_RATE);
  endfunction : has_frame

  function automatic logic inquiry_cmd(input logic [7:0] c);
    inquiry_cmd = has_frame(c) || (c == `BSCI_CMD_INQ_DEV) ||
                  (c == `BSCI_CMD_INQ_MODE) || (c == `BSCI_CMD_INQ_MULT) ||
                  (c == `BSCI_CMD_INQ_FREQ) || (c == `BSCI_CMD_INQ_AREA) ||
                  (c == `BSCI_CMD_INQ_BLK) || (c == `BSCI_CMD_INQ_PSIZE) ||
                  (c == `BSCI_CMD_GO_PROG);
  endfunction : inquiry_cmd

  // Which error, if any, ends the command now being decided
  always_comb begin
    dec_cmd = (state_q == bsci_pkg::BSCI_S_CODE) ? i_rx_data : cmd_q;
    dec_err = `BSCI_ERR_NONE;
    if (state_q == bsci_pkg::BSCI_S_CODE) begin
      if (phase_q == bsci_pkg::BSCI_P_PROGRAM) begin
        if (dec_cmd != `BSCI_CMD_INQ_STATE && dec_cmd != `BSCI_CMD_MEM_READ) begin
          dec_err = `BSCI_ERR_BADCMD;
        end
      end else if (!inquiry_cmd(dec_cmd) && dec_cmd != `BSCI_CMD_INQ_STATE) begin
        dec_err = `BSCI_ERR_BADCMD;
      end
    end else if (sum_q + i_rx_data != `BSCI_ZERO_BYTE) begin
      dec_err = `BSCI_ERR_SUM;
    end else if (cmd_q == `BSCI_CMD_SEL_DEV) begin
      if (size_q != `BSCI_DEV_SIZE || data_q != `BSCI_DEV_CODE) begin
        dec_err = `BSCI_ERR_NODEV;
      end
    end else if (cmd_q == `BSCI_CMD_SEL_MODE) begin
      if (size_q != `BSCI_MODE_SIZE ||
          (data_q[7:0] != `BSCI_MODE_ONE && data_q[7:0] != `BSCI_MODE_TWO)) begin
        dec_err = `BSCI_ERR_NOMODE;
      end
    end
  end

  // Response image, bytes before the checksum, left aligned
  always_comb begin
    rvec    = '0;
    rlen    = `BSCI_TX_ACK;
    rframed = 1'b1;
    if (dec_err != `BSCI_ERR_NONE) begin
      rvec    = {dec_cmd | `BSCI_ERR_FLAG, dec_err, 96'h0};
      rlen    = `BSCI_TX_ERR;
      rframed = 1'b0;
    end else if (has_frame(dec_cmd) || dec_cmd == `BSCI_CMD_GO_PROG) begin
      rvec    = {`BSCI_RSP_ACK, 104'h0};
      rframed = 1'b0;
    end else if (dec_cmd == `BSCI_CMD_INQ_DEV) begin
      rvec = {`BSCI_RSP_DEV, `BSCI_LEN_DEV, `BSCI_DEV_COUNT, `BSCI_DEV_CHARS,
              `BSCI_DEV_CODE, `BSCI_PROD_NAME, 16'h0};
      rlen = `BSCI_TX_DEV;
    end else if (dec_cmd == `BSCI_CMD_INQ_MODE) begin
      rvec = {`BSCI_RSP_MODE, `BSCI_LEN_MODE, `BSCI_MODE_COUNT,
              `BSCI_MODE_ONE, `BSCI_MODE_TWO, 72'h0};
      rlen = `BSCI_TX_MODE;
    end else if (dec_cmd == `BSCI_CMD_INQ_MULT) begin
      // The multiplier follows the selected clock mode; the BSCI_DIV_HALF entry is fixed
      rvec = {`BSCI_RSP_MULT, `BSCI_LEN_MULT, `BSCI_CLK_TYPES, `BSCI_MULT_COUNT,
              (o_sel_mode == `BSCI_MODE_TWO) ? `BSCI_MULT_MID : `BSCI_MULT_HI,
              `BSCI_DIV_HALF, 64'h0};
      rlen = `BSCI_TX_MULT;
    end else if (dec_cmd == `BSCI_CMD_INQ_FREQ) begin
      rvec = {`BSCI_RSP_FREQ, `BSCI_LEN_FREQ, `BSCI_CLK_TYPES,
              `BSCI_FREQ_MIN, `BSCI_FREQ_MAX, 56'h0};
      rlen = `BSCI_TX_FREQ;
    end else if (dec_cmd == `BSCI_CMD_INQ_AREA) begin
      rvec = {`BSCI_RSP_AREA, `BSCI_LEN_AREA, `BSCI_AREA_COUNT,
              `BSCI_FLASH_FIRST, `BSCI_FLASH_LAST, 24'h0};
      rlen = `BSCI_TX_AREA;
    end else if (dec_cmd == `BSCI_CMD_INQ_BLK) begin
      // Two-byte size field on this response
      rvec = {`BSCI_RSP_BLK, `BSCI_ZERO_BYTE, `BSCI_LEN_AREA, `BSCI_AREA_COUNT,
              `BSCI_FLASH_FIRST, `BSCI_FLASH_LAST, 16'h0};
      rlen = `BSCI_TX_BLK;
    end else if (dec_cmd == `BSCI_CMD_INQ_PSIZE) begin
      rvec = {`BSCI_RSP_PSIZE, `BSCI_LEN_PSIZE, `BSCI_PROG_UNIT, 80'h0};
      rlen = `BSCI_TX_PSIZE;
    end else if (dec_cmd == `BSCI_CMD_INQ_STATE) begin
      rvec = {`BSCI_RSP_STATE, `BSCI_LEN_STATE, 6'h0, phase_q,
              last_err_q, 80'h0};
      rlen = `BSCI_TX_STATE;
    end else begin
      // Memory read: contents not served here, only the four-byte size
      rvec = {`BSCI_CMD_MEM_READ, `BSCI_ZERO_WORD, 72'h0};
      rlen = `BSCI_TX_READ;
    end
  end

  logic [8*`BSCI_RESP_BYTES-1:0] resp_q;
  logic [3:0]                    rlen_q;
  logic                          rframed_q;
  logic [3:0]                    idx_q;
  logic [7:0]                    tsum_q;
  logic                          buf_in_ready;
  logic                          gen_push;
  logic [7:0]                    gen_byte;
  logic                          gen_last;

  always_comb begin
    gen_push = (state_q == bsci_pkg::BSCI_S_RESP) && buf_in_ready;
    gen_last = rframed_q ? (idx_q == rlen_q) : (idx_q == rlen_q - 4'h1);
    gen_byte = (idx_q == rlen_q) ? 8'h0 - tsum_q
                                 : resp_q[8*`BSCI_RESP_BYTES-1 -: 8];
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q     <= bsci_pkg::BSCI_S_BAUD;
      phase_q     <= bsci_pkg::BSCI_P_MATCH;
      cmd_q       <= 8'h00;
      size_q      <= 8'h00;
      left_q      <= 8'h00;
      sum_q       <= 8'h00;
      data_q      <= '0;
      resp_q      <= '0;
      rlen_q      <= 4'h0;
      rframed_q   <= 1'b0;
      idx_q       <= 4'h0;
      tsum_q      <= 8'h00;
      o_rx_ready  <= 1'b0;
      o_erase_req <= 1'b0;
      last_err_q  <= 8'h00;
    end else begin
      o_erase_req <= 1'b0;
      case (state_q)
        bsci_pkg::BSCI_S_BAUD: begin
          if (o_rate_locked) begin
            state_q    <= bsci_pkg::BSCI_S_CODE;
            phase_q    <= bsci_pkg::BSCI_P_INQUIRY;
            o_rx_ready <= 1'b1;
          end
        end
        bsci_pkg::BSCI_S_CODE: begin
          if (take) begin
            cmd_q <= i_rx_data;
            sum_q <= i_rx_data;
            if (dec_err == `BSCI_ERR_NONE && has_frame(i_rx_data)) begin
              state_q <= bsci_pkg::BSCI_S_SIZE;
            end else begin
              o_rx_ready <= 1'b0;
              resp_q     <= rvec;
              rlen_q     <= rlen;
              rframed_q  <= rframed;
              idx_q      <= 4'h0;
              tsum_q     <= 8'h00;
              last_err_q <= dec_err;
              state_q    <= (dec_err == `BSCI_ERR_NONE && i_rx_data == `BSCI_CMD_GO_PROG)
                            ? bsci_pkg::BSCI_S_ERASE : bsci_pkg::BSCI_S_RESP;
              o_erase_req <= (dec_err == `BSCI_ERR_NONE &&
                              i_rx_data == `BSCI_CMD_GO_PROG);
            end
          end
        end
        bsci_pkg::BSCI_S_SIZE: begin
          if (take) begin
            size_q  <= i_rx_data;
            left_q  <= i_rx_data;
            sum_q   <= sum_q + i_rx_data;
            data_q  <= '0;
            state_q <= (i_rx_data == 8'h00) ? bsci_pkg::BSCI_S_SUM : bsci_pkg::BSCI_S_DATA;
          end
        end
        bsci_pkg::BSCI_S_DATA: begin
          if (take) begin
            data_q  <= {data_q[23:0], i_rx_data};
            sum_q   <= sum_q + i_rx_data;
            left_q  <= left_q - 8'h01;
            state_q <= (left_q == 8'h01) ? bsci_pkg::BSCI_S_SUM : bsci_pkg::BSCI_S_DATA;
          end
        end
        bsci_pkg::BSCI_S_SUM: begin
          if (take) begin
            o_rx_ready <= 1'b0;
            resp_q     <= rvec;
            rlen_q     <= rlen;
            rframed_q  <= rframed;
            idx_q      <= 4'h0;
            tsum_q     <= 8'h00;
            last_err_q <= dec_err;
            state_q    <= bsci_pkg::BSCI_S_RESP;
          end
        end
        bsci_pkg::BSCI_S_ERASE: begin
          // ACK goes out only once the whole array is erased
          if (i_erase_done) begin
            phase_q <= bsci_pkg::BSCI_P_PROGRAM;
            state_q <= bsci_pkg::BSCI_S_RESP;
          end
        end
        bsci_pkg::BSCI_S_RESP: begin
          if (gen_push) begin
            resp_q <= {resp_q[8*`BSCI_RESP_BYTES-9:0], 8'h00};
            tsum_q <= tsum_q + gen_byte;
            idx_q  <= idx_q + 4'h1;
            if (gen_last) begin
              state_q    <= bsci_pkg::BSCI_S_CODE;
              o_rx_ready <= 1'b1;
            end
          end
        end
        default: state_q <= bsci_pkg::BSCI_S_BAUD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection settings; a repeat simply overwrites, but a rate selection leaves o_new_rate unchanged
  logic sel_ok;

  assign sel_ok = (state_q == bsci_pkg::BSCI_S_SUM) && take && dec_err == `BSCI_ERR_NONE;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      dev_sel_q  <= 8'h00;
      o_sel_mode <= 8'h00;
      o_new_rate <= 16'h0000;
    end else if (sel_ok) begin
      if (cmd_q == `BSCI_CMD_SEL_DEV) begin
        dev_sel_q <= `BSCI_DEV_COUNT;
      end else if (cmd_q == `BSCI_CMD_SEL_MODE) begin
        o_sel_mode <= data_q[7:0];
      end else if (cmd_q == `BSCI_CMD_SEL_RATE && size_q >= 8'h02) begin
        o_new_rate <= o_new_rate;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry transmit buffer: output stage plus a spare, so a stall by the
  // receiver never drops a byte; the spare being full stalls the generator
  logic       spare_v_q;
  logic [7:0] spare_q;
  logic       out_free;

  assign out_free     = !o_tx_valid || i_tx_ready;
  assign buf_in_ready = !spare_v_q;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
      spare_v_q  <= 1'b0;
      spare_q    <= 8'h00;
    end else begin
      if (out_free) begin
        if (spare_v_q) begin
          o_tx_valid <= 1'b1;
          o_tx_data  <= spare_q;
          spare_v_q  <= gen_push;
          spare_q    <= gen_byte;
        end else begin
          o_tx_valid <= gen_push;
          o_tx_data  <= gen_push ? gen_byte : o_tx_data;
        end
      end else if (gen_push) begin
        spare_v_q <= 1'b1;
        spare_q   <= gen_byte;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prog_state <= 1'b0;
    end else begin
      o_prog_state <= (phase_q == bsci_pkg::BSCI_P_PROGRAM);
    end
  end

endmodule : bsci_top

// ==== inc/bsci_params.svh ====
/*
  Constants of the boot serial command interpreter: command and response
  codes, error codes, reported tables and bit-rate matching figures.
  Assumes inclusion by bare name from the design and its bench.
*/
`ifndef BSCI_PARAMS_SVH
`define BSCI_PARAMS_SVH

// Command codes
`define BSCI_CMD_SEL_DEV    8'h10
`define BSCI_CMD_SEL_MODE   8'h11
`define BSCI_CMD_INQ_DEV    8'h20
`define BSCI_CMD_INQ_MODE   8'h21
`define BSCI_CMD_INQ_MULT   8'h22
`define BSCI_CMD_INQ_FREQ   8'h23
`define BSCI_CMD_INQ_AREA   8'h25
`define BSCI_CMD_INQ_BLK    8'h26
`define BSCI_CMD_INQ_PSIZE  8'h27
`define BSCI_CMD_SEL_RATE   8'h3F
`define BSCI_CMD_GO_PROG    8'h40
`define BSCI_CMD_INQ_STATE  8'h4F
`define BSCI_CMD_MEM_READ   8'h52

// Response codes
`define BSCI_RSP_ACK        8'h06
`define BSCI_RSP_DEV        8'h30
`define BSCI_RSP_MODE       8'h31
`define BSCI_RSP_MULT       8'h32
`define BSCI_RSP_FREQ       8'h33
`define BSCI_RSP_AREA       8'h35
`define BSCI_RSP_BLK        8'h36
`define BSCI_RSP_PSIZE      8'h37
`define BSCI_RSP_STATE      8'h5F

// Error response is the command code with this bit set (H'10 -> H'90)
`define BSCI_ERR_FLAG       8'h80
`define BSCI_ERR_NONE       8'h00
`define BSCI_ERR_SUM        8'h11
`define BSCI_ERR_NODEV      8'h21
`define BSCI_ERR_NOMODE     8'h22
`define BSCI_ERR_BADCMD     8'h80

// Reported tables; device code and product name are arbitrary values
`define BSCI_DEV_CODE       32'h4456_3031
`define BSCI_PROD_NAME      32'h424F_4F54
`define BSCI_DEV_COUNT      8'h01
`define BSCI_DEV_CHARS      8'h08
`define BSCI_DEV_SIZE       8'h04
`define BSCI_MODE_SIZE      8'h01
`define BSCI_MODE_COUNT     8'h02
`define BSCI_MODE_ONE       8'h01
`define BSCI_MODE_TWO       8'h02
`define BSCI_CLK_TYPES      8'h01
`define BSCI_MULT_COUNT     8'h02
`define BSCI_MULT_HI        8'h04
`define BSCI_MULT_MID       8'h02
`define BSCI_DIV_HALF       8'hFE
`define BSCI_FREQ_MIN       16'h07D0
`define BSCI_FREQ_MAX       16'h0FA0
`define BSCI_AREA_COUNT     8'h01
`define BSCI_FLASH_FIRST    32'h0000_0000
`define BSCI_FLASH_LAST     32'h0003_FFFF
`define BSCI_PROG_UNIT      16'h0080
`define BSCI_ZERO_BYTE      8'h00
`define BSCI_ZERO_WORD      32'h0000_0000

// Payload lengths carried in size fields
`define BSCI_LEN_DEV        8'h0A
`define BSCI_LEN_MODE       8'h03
`define BSCI_LEN_MULT       8'h04
`define BSCI_LEN_FREQ       8'h05
`define BSCI_LEN_AREA       8'h09
`define BSCI_LEN_PSIZE      8'h02
`define BSCI_LEN_STATE      8'h02

// Bytes sent ahead of the checksum, per response
`define BSCI_TX_DEV         4'hC
`define BSCI_TX_MODE        4'h5
`define BSCI_TX_MULT        4'h6
`define BSCI_TX_FREQ        4'h7
`define BSCI_TX_AREA        4'hB
`define BSCI_TX_BLK         4'hC
`define BSCI_TX_PSIZE       4'h4
`define BSCI_TX_STATE       4'h4
`define BSCI_TX_READ        4'h5
`define BSCI_TX_ACK         4'h1
`define BSCI_TX_ERR         4'h2
`define BSCI_RESP_BYTES     14

// Bit-rate matching: a H'00 byte is low for start bit plus eight data bits
`define BSCI_LOW_BITS       4'h9
`define BSCI_BIT_CNT_W      16

`endif

// ==== inc/bsci_pkg.sv ====
/*
  Types of the boot serial command interpreter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bsci_pkg;

  typedef enum logic [2:0] {
    BSCI_S_BAUD,
    BSCI_S_CODE,
    BSCI_S_SIZE,
    BSCI_S_DATA,
    BSCI_S_SUM,
    BSCI_S_ERASE,
    BSCI_S_RESP
  } bsci_state_t;

  typedef enum logic [1:0] {
    BSCI_P_MATCH,
    BSCI_P_INQUIRY,
    BSCI_P_PROGRAM
  } bsci_phase_t;

endpackage : bsci_pkg

// ==== tb/bsci_host.sv ====
/* Host programmer model: bit-rate preamble, byte sender, byte sink.
   Assumes the tasks are called by the bench; inputs change at falling edges. */
`timescale 1ns/1ps
module bsci_host (
  input  wire logic       i_clock,
  input  wire logic       i_rx_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_rxd,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  logic slow = 1'b0;
  initial begin
    o_rxd = 1'b1;
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_tx_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Start bit plus eight zero bits hold the line low
  task automatic match(input int n);
    @(negedge i_clock) o_rxd = 1'b0;
    repeat (9 * n) @(negedge i_clock);
    o_rxd = 1'b1;
  endtask : match
  // Held until taken, so a stall never loses a byte
  task automatic put(input logic [7:0] b, output bit hung);
    hung = 1'b1;
    @(negedge i_clock);
    o_rx_valid = 1'b1;
    o_rx_data = b;
    for (int k = 0; k < 200 && hung; k++) begin
      @(posedge i_clock);
      if (i_rx_ready === 1'b1) hung = 1'b0;
    end
  endtask : put
  // Released data shows the inverse so a stale byte cannot pass
  task automatic drop;
    @(negedge i_clock);
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data;
  endtask : drop
  task automatic get(output logic [7:0] b, output bit hung);
    hung = 1'b1;
    for (int k = 0; k < 200 && hung; k++) begin
      @(negedge i_clock);
      o_tx_ready = slow ? ~o_tx_ready : 1'b1;
      @(posedge i_clock);
      if (i_tx_valid === 1'b1 && o_tx_ready) begin
        b = i_tx_data;
        hung = 1'b0;
      end
    end
    @(negedge i_clock) o_tx_ready = 1'b0;
  endtask : get
endmodule : bsci_host

// ==== tb/bsci_props.sv ====
/* Checker of bsci_top port behaviour.
   Assumes the single clock and the async active-low reset of bsci_top. */
`timescale 1ns/1ps
module bsci_props (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_erase_done,
  input wire logic        i_tx_ready,
  input wire logic        o_rx_ready,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic [15:0] o_bit_cycles,
  input wire logic        o_rate_locked,
  input wire logic        o_erase_req,
  input wire logic [7:0]  o_sel_mode,
  input wire logic        o_prog_state
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_erase;
    o_erase_req ##[1:1000] i_erase_done;
  endsequence
  sequence s_ack;
    o_tx_valid && o_tx_data == 8'h06;
  endsequence
  rx_gate_a: assert property (!o_rate_locked |-> !o_rx_ready)
    else $error("byte accepted before rate lock");
  lock_held_a: assert property (o_rate_locked |=> o_rate_locked && $stable(o_bit_cycles))
    else $error("rate lock lost or changed");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("stalled byte not held");
  erase_pulse_a: assert property (o_erase_req |=> !o_erase_req)
    else $error("erase request longer than one cycle");
  erase_ack_a: assert property (s_erase |-> ##2 s_ack)
    else $error("no ack two cycles after erase done");
  erase_first_a: assert property (o_erase_req |-> !o_prog_state)
    else $error("erase requested after transition");
  prog_held_a: assert property (o_prog_state |=> o_prog_state)
    else $error("programming state left");
  mode_legal_a: assert property (o_sel_mode inside {8'h00, 8'h01, 8'h02})
    else $error("unlisted clock mode kept");
endmodule : bsci_props

bind bsci_top bsci_props u_props (.i_clock, .i_rstn, .i_erase_done, .i_tx_ready, .o_rx_ready,
  .o_tx_valid, .o_tx_data, .o_bit_cycles, .o_rate_locked, .o_erase_req, .o_sel_mode,
  .o_prog_state);

// ==== tb/bsci_tb_top.sv ====
/* Bench of bsci_top: host model on the byte side, erase engine here.
   Assumes bsci_host and bsci_props are compiled first. */
`timescale 1ns/1ps
`include "bsci_params.svh"
module bsci_tb_top;
  typedef logic [7:0] bsci_q_t [$];
  localparam logic [31:0] DEV = `BSCI_DEV_CODE;
  localparam logic [31:0] NM  = `BSCI_PROD_NAME;
  logic        clock, rstn, rxd, rx_valid, rx_ready, tx_valid, tx_ready;
  logic        locked, erase_req, erase_done, prog;
  logic [7:0]  rx_data, tx_data, sel_mode;
  logic [15:0] bit_cycles;
  int          failures = 0;
  int          compares = 0;
  bsci_q_t     dv;
  bsci_top dut (.i_clock(clock), .i_rstn(rstn), .i_rxd(rxd), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .o_bit_cycles(bit_cycles), .o_rate_locked(locked),
    .o_erase_req(erase_req), .i_erase_done(erase_done), .o_sel_mode(sel_mode),
    .o_new_rate(), .o_prog_state(prog));
  bsci_host host (.i_clock(clock), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_rxd(rxd), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic stall;
    failures++;
    end_of_test();
  endtask : stall
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Appends the byte that brings the frame sum to zero
  function automatic bsci_q_t fr(input bsci_q_t q);
    logic [7:0] s = 8'h00;
    foreach (q[i]) s -= q[i];
    return {q, s};
  endfunction : fr
  // Erase engine: answers the request pulse after one cycle
  task automatic erase;
    int k;
    for (k = 0; k < 50 && erase_req !== 1'b1; k++) @(negedge clock);
    if (k == 50) stall();
    // A later cycle, so the done pulse never lands in the request's own cycle
    @(negedge clock);
    erase_done = 1'b1;
    @(negedge clock);
    erase_done = 1'b0;
  endtask : erase
  // Unknown expected bytes are skipped; the zero-sum check still covers them
  task automatic xact(input string what, input bsci_q_t cmd, input bsci_q_t exp);
    logic [7:0] b, s;
    bit         hung;
    s = 8'h00;
    foreach (cmd[i]) begin
      host.put(cmd[i], hung);
      if (hung) stall();
    end
    host.drop();
    if (cmd[0] == `BSCI_CMD_GO_PROG) erase();
    foreach (exp[i]) begin
      host.get(b, hung);
      if (hung) stall();
      s += b;
      if (!$isunknown(exp[i])) check(what, b, exp[i]);
    end
    if (exp.size() > 2) check("sum", s, 8'h00);
  endtask : xact
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_lock;
    host.match(4);
    for (int k = 0; k < 20 && locked !== 1'b1; k++) @(negedge clock);
    check("locked", locked, 1'b1);
    check("bit cycles", bit_cycles, 16'h0004);
    $display("lock test done");
  endtask : t_lock
  task automatic t_inquire;
    xact("dev", {8'h20}, fr({8'h30, 8'h0A, 8'h01, 8'h08, dv, NM[31:24], NM[23:16],
      NM[15:8], NM[7:0]}));
    xact("modes", {8'h21}, fr({8'h31, 8'h03, 8'h02, 8'h01, 8'h02}));
    xact("state", {8'h4F}, fr({8'h5F, 8'h02, 8'h01, 8'h00}));
    $display("inquiry test done");
  endtask : t_inquire
  task automatic t_select;
    bsci_q_t q;
    host.slow = 1'b1;
    q = fr({8'h10, 8'h04, dv});
    q[6] = q[6] ^ 8'h01;
    xact("dev sum", q, {8'h90, 8'h11});
    xact("dev code", fr({8'h10, 8'h04, dv[0:2], 8'h32}), {8'h90, 8'h21});
    xact("dev ok", fr({8'h10, 8'h04, dv}), {8'h06});
    xact("mode 2", fr({8'h11, 8'h01, 8'h02}), {8'h06});
    check("mode", sel_mode, 8'h02);
    xact("mode 1", fr({8'h11, 8'h01, 8'h01}), {8'h06});
    xact("mode 3", fr({8'h11, 8'h01, 8'h03}), {8'h91, 8'h22});
    xact("mode sum", {8'h11, 8'h01, 8'h01, 8'h00}, {8'h91, 8'h11});
    check("mode", sel_mode, 8'h01);
    xact("mult", {8'h22}, fr({8'h32, 8'h04, 8'h01, 8'h02, 8'h04, 8'hFE}));
    xact("freq", {8'h23}, fr({8'h33, 8'h05, 8'h01, 8'h07, 8'hD0, 8'h0F, 8'hA0}));
    xact("unit", {8'h27}, fr({8'h37, 8'h02, 8'h00, 8'h80}));
    xact("blocks", {8'h26}, fr({8'h36, 8'h00, 8'h09, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h03, 8'hFF, 8'hFF}));
    xact("rate", fr({8'h3F, 8'h01, 8'h00}), {8'h06});
    host.slow = 1'b0;
    $display("selection test done");
  endtask : t_select
  task automatic t_prog;
    check("prog", prog, 1'b0);
    xact("go", {8'h40}, {8'h06});
    check("prog", prog, 1'b1);
    xact("late dev", {8'h20}, {8'hA0, 8'h80});
    xact("state", {8'h4F}, fr({8'h5F, 8'h02, 8'h02, 8'h80}));
    xact("read", {8'h52}, fr({8'h52, 8'h00, 8'h00, 8'h00, 8'h00}));
    $display("programming test done");
  endtask : t_prog
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    erase_done = 1'b0;
    dv = {DEV[31:24], DEV[23:16], DEV[15:8], DEV[7:0]};
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    t_lock();
    t_inquire();
    t_select();
    t_prog();
    end_of_test();
  end
endmodule : bsci_tb_top
